//--- verilog/flow_chan_pkg.sv
// Constants for service flow deletion and channel change control
package flow_chan_pkg;
   // Clock rate
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
   // Old-channel hold time, in ms (plain default, no figure given)
   localparam int unsigned T13_MS = 1000;
   localparam int unsigned T13_CYCLES = T13_MS * CYCLES_PER_MS;
   // Margin before hold expiry at which the jump is forced, in ms
   localparam int unsigned DEPART_MARGIN_MS = 1;
   localparam int unsigned DEPART_MARGIN_CYCLES = DEPART_MARGIN_MS * CYCLES_PER_MS;
   // Initialization technique codes carried in the change request
   localparam logic [2:0] TECH_REINIT = 3'h0;
   localparam logic [2:0] TECH_INIT_RANGE = 3'h1;
   localparam logic [2:0] TECH_STATION_MAINT = 3'h2;
   localparam logic [2:0] TECH_DIRECT = 3'h3;
   // Deletion response status
   localparam logic RSP_OK = 1'h1;
   localparam logic RSP_REJECT = 1'h0;
endpackage

//--- verilog/hold_timer.sv
// Restartable down-counter for hold and departure deadlines
`timescale 1ns/1ps
module hold_timer #(
   parameter int W = 32
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Control
   input wire logic start,
   input wire logic stop,
   input wire logic [W-1:0] load_val,
   // Status
   output logic running,
   output logic expired
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic next_running;
   logic next_expired;

   initial
   begin
      if (W < 2) $error("hold_timer: W too small");
   end

   always_comb
   begin
      next_count = count;
      next_running = running;
      next_expired = 1'b0;
      if (start)
      begin
         next_count = load_val;
         next_running = 1'b1;
      end
      else if (stop)
      begin
         next_running = 1'b0;
      end
      else if (running)
      begin
         if (count <= W'(1))
         begin
            next_running = 1'b0;
            next_expired = 1'b1;
         end
         else
         begin
            next_count = count - W'(1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end
      else
      begin
         count <= next_count;
         running <= next_running;
         expired <= next_expired;
      end
   end
endmodule

//--- verilog/flow_chan_ctrl.sv
// Modem-side service flow deletion and channel change control
`timescale 1ns/1ps
module flow_chan_ctrl #(
   parameter int SFID_W = 32,
   parameter int unsigned T13_CYCLES = flow_chan_pkg::T13_CYCLES,
   parameter int unsigned DEPART_MARGIN_CYCLES = flow_chan_pkg::DEPART_MARGIN_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Registration context
   input wire logic registered,
   input wire logic [SFID_W-1:0] primary_us_sfid,
   input wire logic [SFID_W-1:0] primary_ds_sfid,
   input wire logic [SFID_W-1:0] prov_us_sfid,
   input wire logic [SFID_W-1:0] prov_ds_sfid,
   // Local deletion request
   input wire logic loc_del_req,
   input wire logic loc_del_us_valid,
   input wire logic loc_del_ds_valid,
   input wire logic [SFID_W-1:0] loc_del_us_sfid,
   input wire logic [SFID_W-1:0] loc_del_ds_sfid,
   // Deletion messages received
   input wire logic rx_dsd_req,
   input wire logic rx_dsd_us_valid,
   input wire logic rx_dsd_ds_valid,
   input wire logic [SFID_W-1:0] rx_dsd_us_sfid,
   input wire logic [SFID_W-1:0] rx_dsd_ds_sfid,
   input wire logic rx_dsd_rsp,
   // Deletion messages sent
   output logic tx_dsd_req,
   output logic tx_dsd_us_valid,
   output logic tx_dsd_ds_valid,
   output logic [SFID_W-1:0] tx_dsd_us_sfid,
   output logic [SFID_W-1:0] tx_dsd_ds_sfid,
   output logic tx_dsd_rsp,
   output logic tx_dsd_rsp_ok,
   // Flow release, registration effects and deletion busy status
   output logic free_us_flow,
   output logic free_ds_flow,
   output logic [SFID_W-1:0] free_us_sfid,
   output logic [SFID_W-1:0] free_ds_sfid,
   output logic rereg,
   output logic prov_lost,
   output logic dsd_busy,
   // Channel change messages
   input wire logic rx_dcc_req,
   input wire logic rx_dcc_tech_present,
   input wire logic [2:0] rx_dcc_tech,
   output logic tx_dcc_rsp_depart,
   output logic tx_dcc_rsp_arrive,
   // Channel change sequencing
   input wire logic jump_ready,
   input wire logic sync_done,
   input wire logic range_done,
   input wire logic range_abort,
   output logic old_ch_use,
   output logic new_ch_use,
   output logic jump_now,
   output logic bw_flush,
   output logic mac_reinit,
   output logic range_start,
   output logic dcc_fail
);
   typedef enum logic [0:0] {DSD_IDLE, DSD_WAIT_RSP} dsd_state_t;
   typedef enum logic [2:0] {DCC_IDLE, DCC_OLD, DCC_SYNC, DCC_RANGE, DCC_ARRIVE} dcc_state_t;

   localparam int TW = 32;

   initial
   begin
      if (SFID_W < 1) $error("flow_chan_ctrl: SFID_W must be positive");
      if (DEPART_MARGIN_CYCLES >= T13_CYCLES) $error("flow_chan_ctrl: margin exceeds hold");
   end

   function automatic logic hit(input logic v, input logic [SFID_W-1:0] a,
                                input logic [SFID_W-1:0] b);
      hit = v && (a == b);
   endfunction

   // Deletion state
   dsd_state_t dsd_state, next_dsd_state;
   logic next_tx_dsd_req, next_tx_dsd_us_valid, next_tx_dsd_ds_valid;
   logic [SFID_W-1:0] next_tx_dsd_us_sfid, next_tx_dsd_ds_sfid;
   logic next_tx_dsd_rsp, next_tx_dsd_rsp_ok;
   logic next_free_us_flow, next_free_ds_flow;
   logic [SFID_W-1:0] next_free_us_sfid, next_free_ds_sfid;
   logic next_rereg, next_prov_lost;
   logic del_go, del_us_v, del_ds_v;
   logic [SFID_W-1:0] del_us_id, del_ds_id;

   always_comb
   begin
      next_dsd_state = dsd_state;
      next_tx_dsd_req = 1'b0;
      next_tx_dsd_us_valid = tx_dsd_us_valid;
      next_tx_dsd_ds_valid = tx_dsd_ds_valid;
      next_tx_dsd_us_sfid = tx_dsd_us_sfid;
      next_tx_dsd_ds_sfid = tx_dsd_ds_sfid;
      next_tx_dsd_rsp = 1'b0;
      next_tx_dsd_rsp_ok = tx_dsd_rsp_ok;
      // Headend request takes precedence over a new local one
      del_go = 1'b0;
      del_us_v = 1'b0;
      del_ds_v = 1'b0;
      del_us_id = rx_dsd_us_sfid;
      del_ds_id = rx_dsd_ds_sfid;
      if (rx_dsd_req)
      begin
         // Port form carries at most one flow each way
         del_go = 1'b1;
         del_us_v = rx_dsd_us_valid;
         del_ds_v = rx_dsd_ds_valid;
         next_tx_dsd_rsp = 1'b1;
         next_tx_dsd_rsp_ok = (rx_dsd_us_valid || rx_dsd_ds_valid) ? flow_chan_pkg::RSP_OK
                                                                   : flow_chan_pkg::RSP_REJECT;
      end
      else if (loc_del_req && dsd_state == DSD_IDLE
               && (loc_del_us_valid || loc_del_ds_valid))
      begin
         // Modem deletes locally and asks the headend in the same cycle
         del_go = 1'b1;
         del_us_v = loc_del_us_valid;
         del_ds_v = loc_del_ds_valid;
         del_us_id = loc_del_us_sfid;
         del_ds_id = loc_del_ds_sfid;
         next_tx_dsd_req = 1'b1;
         next_tx_dsd_us_valid = loc_del_us_valid;
         next_tx_dsd_ds_valid = loc_del_ds_valid;
         next_tx_dsd_us_sfid = loc_del_us_sfid;
         next_tx_dsd_ds_sfid = loc_del_ds_sfid;
         next_dsd_state = DSD_WAIT_RSP;
      end
      if (dsd_state == DSD_WAIT_RSP && rx_dsd_rsp)
      begin
         next_dsd_state = DSD_IDLE;
      end
      // Release of the flow and everything tied to it
      next_free_us_flow = del_go && del_us_v;
      next_free_ds_flow = del_go && del_ds_v;
      next_free_us_sfid = del_us_v ? del_us_id : free_us_sfid;
      next_free_ds_sfid = del_ds_v ? del_ds_id : free_ds_sfid;
      next_rereg = del_go && (hit(del_us_v, del_us_id, primary_us_sfid)
                              || hit(del_ds_v, del_ds_id, primary_ds_sfid));
      // Provisioned loss alone never asks for re-registration
      next_prov_lost = del_go && (hit(del_us_v, del_us_id, prov_us_sfid)
                                  || hit(del_ds_v, del_ds_id, prov_ds_sfid));
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dsd_state <= DSD_IDLE;
         tx_dsd_req <= 1'b0;
         tx_dsd_us_valid <= 1'b0;
         tx_dsd_ds_valid <= 1'b0;
         tx_dsd_us_sfid <= '0;
         tx_dsd_ds_sfid <= '0;
         tx_dsd_rsp <= 1'b0;
         tx_dsd_rsp_ok <= 1'b0;
         free_us_flow <= 1'b0;
         free_ds_flow <= 1'b0;
         free_us_sfid <= '0;
         free_ds_sfid <= '0;
         rereg <= 1'b0;
         prov_lost <= 1'b0;
         dsd_busy <= 1'b0;
      end
      else
      begin
         dsd_state <= next_dsd_state;
         tx_dsd_req <= next_tx_dsd_req;
         tx_dsd_us_valid <= next_tx_dsd_us_valid;
         tx_dsd_ds_valid <= next_tx_dsd_ds_valid;
         tx_dsd_us_sfid <= next_tx_dsd_us_sfid;
         tx_dsd_ds_sfid <= next_tx_dsd_ds_sfid;
         tx_dsd_rsp <= next_tx_dsd_rsp;
         tx_dsd_rsp_ok <= next_tx_dsd_rsp_ok;
         free_us_flow <= next_free_us_flow;
         free_ds_flow <= next_free_ds_flow;
         free_us_sfid <= next_free_us_sfid;
         free_ds_sfid <= next_free_ds_sfid;
         rereg <= next_rereg;
         prov_lost <= next_prov_lost;
         dsd_busy <= (next_dsd_state == DSD_WAIT_RSP);
      end
   end

   // Channel change state
   dcc_state_t dcc_state, next_dcc_state;
   logic [2:0] tech, next_tech;
   logic next_tx_dcc_rsp_depart, next_tx_dcc_rsp_arrive;
   logic next_old_ch_use, next_new_ch_use, next_jump_now, next_bw_flush;
   logic next_mac_reinit, next_range_start, next_dcc_fail;
   logic depart_start, depart_expired;
   logic take_req;

   always_comb
   begin
      next_dcc_state = dcc_state;
      next_tech = tech;
      next_tx_dcc_rsp_depart = 1'b0;
      next_tx_dcc_rsp_arrive = 1'b0;
      next_old_ch_use = old_ch_use;
      next_new_ch_use = new_ch_use;
      next_jump_now = 1'b0;
      next_bw_flush = 1'b0;
      next_mac_reinit = 1'b0;
      next_range_start = 1'b0;
      next_dcc_fail = 1'b0;
      // Requests are honoured only while registered; repeats restart the deadline
      take_req = rx_dcc_req && registered && (dcc_state == DCC_IDLE || dcc_state == DCC_OLD);
      depart_start = take_req;
      case (dcc_state)
         DCC_IDLE:
         begin
            if (take_req)
            begin
               // Missing technique field means full re-initialization
               next_tech = rx_dcc_tech_present ? rx_dcc_tech : flow_chan_pkg::TECH_REINIT;
               next_tx_dcc_rsp_depart = 1'b1;
               next_old_ch_use = 1'b1;
               next_dcc_state = DCC_OLD;
            end
         end
         DCC_OLD:
         begin
            if (take_req)
            begin
               next_tech = rx_dcc_tech_present ? rx_dcc_tech : flow_chan_pkg::TECH_REINIT;
               next_tx_dcc_rsp_depart = 1'b1;
            end
            else if (jump_ready || depart_expired)
            begin
               // Leave before the old-channel hold runs out
               next_jump_now = 1'b1;
               next_old_ch_use = 1'b0;
               next_bw_flush = 1'b1;
               next_dcc_state = DCC_SYNC;
            end
         end
         DCC_SYNC:
         begin
            if (sync_done)
            begin
               case (tech)
                  flow_chan_pkg::TECH_INIT_RANGE, flow_chan_pkg::TECH_STATION_MAINT:
                  begin
                     next_range_start = 1'b1;
                     next_new_ch_use = 1'b1;
                     next_dcc_state = DCC_RANGE;
                  end
                  flow_chan_pkg::TECH_DIRECT:
                  begin
                     next_new_ch_use = 1'b1;
                     next_dcc_state = DCC_ARRIVE;
                  end
                  default:
                  begin
                     // Full restart, no arrive message on the new channel
                     next_mac_reinit = 1'b1;
                     next_dcc_state = DCC_IDLE;
                  end
               endcase
            end
         end
         DCC_RANGE:
         begin
            if (range_abort)
            begin
               next_dcc_fail = 1'b1;
               next_new_ch_use = 1'b0;
               next_dcc_state = DCC_IDLE;
            end
            else if (range_done)
            begin
               next_dcc_state = DCC_ARRIVE;
            end
         end
         DCC_ARRIVE:
         begin
            next_tx_dcc_rsp_arrive = 1'b1;
            next_new_ch_use = 1'b0;
            next_dcc_state = DCC_IDLE;
         end
         default:
         begin
            next_dcc_state = DCC_IDLE;
         end
      endcase
   end

   // Departure deadline, restarted by each accepted request
   hold_timer #(
      .W(TW)
   ) u_depart_timer (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .start(depart_start),
      .stop(next_jump_now),
      .load_val(TW'(T13_CYCLES - DEPART_MARGIN_CYCLES)),
      .running(),
      .expired(depart_expired)
   );

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dcc_state <= DCC_IDLE;
         tech <= flow_chan_pkg::TECH_REINIT;
         tx_dcc_rsp_depart <= 1'b0;
         tx_dcc_rsp_arrive <= 1'b0;
         old_ch_use <= 1'b0;
         new_ch_use <= 1'b0;
         jump_now <= 1'b0;
         bw_flush <= 1'b0;
         mac_reinit <= 1'b0;
         range_start <= 1'b0;
         dcc_fail <= 1'b0;
      end
      else
      begin
         dcc_state <= next_dcc_state;
         tech <= next_tech;
         tx_dcc_rsp_depart <= next_tx_dcc_rsp_depart;
         tx_dcc_rsp_arrive <= next_tx_dcc_rsp_arrive;
         old_ch_use <= next_old_ch_use;
         new_ch_use <= next_new_ch_use;
         jump_now <= next_jump_now;
         bw_flush <= next_bw_flush;
         mac_reinit <= next_mac_reinit;
         range_start <= next_range_start;
         dcc_fail <= next_dcc_fail;
      end
   end
endmodule

//--- tb/flow_chan_checker.sv
// Assertions on the deletion and channel change controller ports
`timescale 1ns/1ps
module flow_chan_checker #(
   parameter int SFID_W = 32,
   parameter int unsigned T13_CYCLES = 100
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Deletion
   input wire logic [SFID_W-1:0] primary_us_sfid,
   input wire logic [SFID_W-1:0] prov_us_sfid,
   input wire logic loc_del_req,
   input wire logic loc_del_us_valid,
   input wire logic loc_del_ds_valid,
   input wire logic rx_dsd_req,
   input wire logic rx_dsd_us_valid,
   input wire logic rx_dsd_ds_valid,
   input wire logic [SFID_W-1:0] rx_dsd_us_sfid,
   input wire logic tx_dsd_req,
   input wire logic tx_dsd_rsp,
   input wire logic tx_dsd_rsp_ok,
   input wire logic free_us_flow,
   input wire logic [SFID_W-1:0] free_us_sfid,
   input wire logic rereg,
   input wire logic prov_lost,
   input wire logic dsd_busy,
   // Channel change
   input wire logic registered,
   input wire logic rx_dcc_req,
   input wire logic rx_dcc_tech_present,
   input wire logic [2:0] rx_dcc_tech,
   input wire logic tx_dcc_rsp_depart,
   input wire logic tx_dcc_rsp_arrive,
   input wire logic sync_done,
   input wire logic range_abort,
   input wire logic old_ch_use,
   input wire logic new_ch_use,
   input wire logic jump_now,
   input wire logic bw_flush,
   input wire logic mac_reinit,
   input wire logic range_start,
   input wire logic dcc_fail
);
   logic [2:0] tq;
   logic jumped;
   logic reinit_q;
   int unsigned old_cnt;
   assign reinit_q = (tq == flow_chan_pkg::TECH_REINIT) || (tq > flow_chan_pkg::TECH_DIRECT);
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tq <= 3'h0;
         jumped <= 1'b0;
         old_cnt <= 0;
      end
      else
      begin
         if (rx_dcc_req && registered)
            tq <= rx_dcc_tech_present ? rx_dcc_tech : flow_chan_pkg::TECH_REINIT;
         jumped <= jump_now ? 1'b1 : (sync_done ? 1'b0 : jumped);
         old_cnt <= (rx_dcc_req && registered) ? 0 : (old_ch_use ? old_cnt + 1 : 0);
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   sequence arrive_s;
      new_ch_use ##1 tx_dcc_rsp_arrive;
   endsequence
   sequence no_arrive_s;
      !tx_dcc_rsp_arrive [*4];
   endsequence
   del_rsp_a: assert property (rx_dsd_req |=> tx_dsd_rsp &&
      tx_dsd_rsp_ok == ($past(rx_dsd_us_valid) || $past(rx_dsd_ds_valid)))
      else $error("deletion response wrong");
   free_us_a: assert property (rx_dsd_req && rx_dsd_us_valid |=> free_us_flow &&
      free_us_sfid == $past(rx_dsd_us_sfid)) else $error("flow not freed");
   rereg_a: assert property (rx_dsd_req && rx_dsd_us_valid &&
      rx_dsd_us_sfid == primary_us_sfid |=> rereg) else $error("no re-registration");
   prov_a: assert property (rx_dsd_req && rx_dsd_us_valid && !rx_dsd_ds_valid &&
      rx_dsd_us_sfid == prov_us_sfid && rx_dsd_us_sfid != primary_us_sfid
      |=> prov_lost && !rereg) else $error("provisioned deletion wrong");
   loc_req_a: assert property (loc_del_req && !rx_dsd_req && !dsd_busy &&
      (loc_del_us_valid || loc_del_ds_valid) |=> tx_dsd_req && dsd_busy)
      else $error("local request not sent");
   one_out_a: assert property (dsd_busy && loc_del_req |=> !tx_dsd_req)
      else $error("second request sent");
   depart_a: assert property (rx_dcc_req && registered && !jumped && !new_ch_use
      |=> tx_dcc_rsp_depart && old_ch_use) else $error("no depart");
   hold_a: assert property (old_ch_use |-> old_cnt < T13_CYCLES)
      else $error("old channel kept too long");
   jump_a: assert property (jump_now |-> bw_flush && !old_ch_use)
      else $error("jump without flush");
   reinit_a: assert property (sync_done && jumped && reinit_q
      |=> mac_reinit && !new_ch_use ##1 no_arrive_s) else $error("reinit wrong");
   range_a: assert property (sync_done && jumped && !reinit_q |=> new_ch_use &&
      range_start == ($past(tq) != flow_chan_pkg::TECH_DIRECT)) else $error("ranging wrong");
   direct_a: assert property (sync_done && jumped && tq == flow_chan_pkg::TECH_DIRECT
      |=> arrive_s) else $error("direct arrive missing");
   abort_a: assert property (range_abort && new_ch_use |=> dcc_fail && !new_ch_use)
      else $error("abort not failed");
endmodule
bind flow_chan_ctrl flow_chan_checker #(.SFID_W(SFID_W), .T13_CYCLES(T13_CYCLES)) u_chk (.*);

//--- tb/headend_model.sv
// Headend model answering the modem's deletion requests
`timescale 1ns/1ps
module headend_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Answer delay in cycles
   input wire logic [7:0] lat,
   // Deletion exchange
   input wire logic tx_dsd_req,
   output logic rx_dsd_rsp
);
   int cnt;
   // Owner check and delete take lat cycles, then answer
   always @(negedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt = 0;
         rx_dsd_rsp <= 1'b0;
      end
      else
      begin
         rx_dsd_rsp <= (cnt == 1);
         if (tx_dsd_req)
            cnt = lat + 1;
         else if (cnt > 0)
            cnt = cnt - 1;
      end
   end
endmodule

//--- tb/service_delete_channel_change_tb.sv
// Self-checking bench for deletion and channel change control
`timescale 1ns/1ps
module service_delete_channel_change_tb;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic registered, loc_del_req, loc_del_us_valid, loc_del_ds_valid, rx_dsd_req, rx_dsd_rsp;
   logic rx_dsd_us_valid, rx_dsd_ds_valid, rx_dcc_req, rx_dcc_tech_present, jump_ready;
   logic sync_done, range_done, range_abort, tx_dsd_req, tx_dsd_us_valid, tx_dsd_ds_valid;
   logic [2:0] rx_dcc_tech;
   logic [31:0] primary_us_sfid, primary_ds_sfid, prov_us_sfid, prov_ds_sfid, loc_del_us_sfid;
   logic [31:0] loc_del_ds_sfid, rx_dsd_us_sfid, rx_dsd_ds_sfid, tx_dsd_us_sfid, tx_dsd_ds_sfid;
   logic [31:0] free_us_sfid, free_ds_sfid, r;
   logic tx_dsd_rsp, tx_dsd_rsp_ok, free_us_flow, free_ds_flow, rereg, prov_lost, dsd_busy;
   logic tx_dcc_rsp_depart, tx_dcc_rsp_arrive, old_ch_use, new_ch_use, jump_now, bw_flush;
   logic mac_reinit, range_start, dcc_fail;
   logic [7:0] lat;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 32'hdb8a;
   int n;
   assign rx_dsd_us_valid = loc_del_us_valid;
   assign rx_dsd_ds_valid = loc_del_ds_valid;
   assign rx_dsd_us_sfid = loc_del_us_sfid;
   assign rx_dsd_ds_sfid = loc_del_ds_sfid;
   flow_chan_ctrl #(.T13_CYCLES(100), .DEPART_MARGIN_CYCLES(10)) u_dut (.*);
   headend_model u_he (.*);
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   function automatic logic hit(input logic uv, dv, input logic [31:0] us, ds, a, b);
      return (uv && us === a) || (dv && ds === b);
   endfunction
   function automatic logic [31:0] pick(input logic [31:0] v);
      return (v[1:0] == 0) ? primary_us_sfid : ((v[1:0] == 1) ? prov_ds_sfid : v);
   endfunction
   task automatic del(input logic loc, uv, dv, input logic [31:0] us, ds, input logic take);
      loc_del_req = loc;
      rx_dsd_req = !loc;
      {loc_del_us_valid, loc_del_ds_valid, loc_del_us_sfid, loc_del_ds_sfid} = {uv, dv, us, ds};
      @(negedge core_clk);
      loc_del_req = 1'b0;
      rx_dsd_req = 1'b0;
      if (loc)
         chk("req_sent", tx_dsd_req, take);
      else
         chk("rsp_ok", {tx_dsd_rsp, tx_dsd_rsp_ok}, {1'b1, uv | dv});
      if (loc && take)
         chk("req_fields", {dsd_busy, tx_dsd_us_valid, tx_dsd_ds_valid}, {1'b1, uv, dv});
      if (loc && take && uv)
         chk("req_us", tx_dsd_us_sfid, us);
      if (loc && take && dv)
         chk("req_ds", tx_dsd_ds_sfid, ds);
      if (take)
      begin
         chk("free", {free_us_flow, free_ds_flow}, {uv, dv});
         if (uv)
            chk("free_us_id", free_us_sfid, us);
         if (dv)
            chk("free_ds_id", free_ds_sfid, ds);
         chk("rereg", rereg, hit(uv, dv, us, ds, primary_us_sfid, primary_ds_sfid));
         chk("prov", prov_lost, hit(uv, dv, us, ds, prov_us_sfid, prov_ds_sfid));
      end
      // Idle cycle keeps back-to-back requests apart
      @(negedge core_clk);
   endtask
   task automatic dcc(input logic pres, input logic [2:0] tech, input logic abrt, forced);
      logic reinit;
      reinit = !pres || tech == 3'h0 || tech > 3'h3;
      rx_dcc_req = 1'b1;
      {rx_dcc_tech_present, rx_dcc_tech} = {pres, tech};
      @(negedge core_clk);
      rx_dcc_req = 1'b0;
      chk("depart", {tx_dcc_rsp_depart, old_ch_use}, {registered, registered});
      if (!registered)
         return;
      if (forced)
      begin
         repeat (40) @(negedge core_clk);
         rx_dcc_req = 1'b1;
         @(negedge core_clk);
         rx_dcc_req = 1'b0;
         for (n = 0; old_ch_use === 1'b1 && n < 200; n++)
            @(negedge core_clk);
         chk("deadline", n >= 80 && n < 100, 1);
      end
      else
      begin
         repeat (1 + {$random(seed)} % 10) @(negedge core_clk);
         jump_ready = 1'b1;
         @(negedge core_clk);
         jump_ready = 1'b0;
      end
      chk("jump", {jump_now, bw_flush, old_ch_use}, 3'h6);
      repeat (3) @(negedge core_clk);
      sync_done = 1'b1;
      @(negedge core_clk);
      sync_done = 1'b0;
      chk("tech", {mac_reinit, new_ch_use}, {reinit, !reinit});
      chk("range", range_start, pres && (tech == 3'h1 || tech == 3'h2));
      if (!reinit && tech != 3'h3)
      begin
         repeat (2) @(negedge core_clk);
         {range_abort, range_done} = {abrt, !abrt};
         @(negedge core_clk);
         {range_abort, range_done} = 2'h0;
         chk("fail", dcc_fail, abrt);
      end
      // Reinit path must stay silent on the new channel
      for (n = 0; n < (reinit ? 4 : 1); n++)
      begin
         @(negedge core_clk);
         chk("arrive", tx_dcc_rsp_arrive, !reinit && !abrt);
      end
      chk("new_off", new_ch_use, 0);
   endtask
   initial
   begin
      {registered, loc_del_req, rx_dsd_req, rx_dcc_req, jump_ready, sync_done} = 6'h00;
      {range_done, range_abort, rx_dcc_tech_present, rx_dcc_tech, lat} = 13'h0000;
      {loc_del_us_valid, loc_del_ds_valid, loc_del_us_sfid, loc_del_ds_sfid} = 66'h0;
      {primary_us_sfid, primary_ds_sfid} = {$random(seed), $random(seed)};
      {prov_us_sfid, prov_ds_sfid} = {$random(seed), $random(seed)};
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      del(0, 0, 0, 32'h0, 32'h0, 1);
      del(0, 1, 0, primary_us_sfid, 32'h0, 1);
      del(0, 1, 0, prov_us_sfid, 32'h0, 1);
      del(0, 0, 1, 32'h1, primary_ds_sfid, 1);
      repeat (30)
      begin
         r = $random(seed);
         del(r[2], r[3] | r[2], r[4], pick($random(seed)), pick($random(seed)), 1);
         for (n = 0; dsd_busy !== 1'b0 && n < 40; n++)
            @(negedge core_clk);
      end
      $display("test remote and random deletion done");
      lat = 8'h14;
      del(1, 1, 1, prov_us_sfid, prov_ds_sfid, 1);
      del(1, 1, 0, 32'h5, 32'h0, 0);
      for (n = 0; dsd_busy !== 1'b0 && n < 100; n++)
         @(negedge core_clk);
      chk("busy_clear", n > 15 && n < 30, 1);
      del(1, 0, 0, 32'h5, 32'h6, 0);
      $display("test local deletion done");
      dcc(1, 3'h1, 0, 0);
      registered = 1'b1;
      for (int i = 0; i < 8; i++)
         dcc(i != 0, (i == 7) ? 3'h3 : ((i == 6) ? 3'h1 : 3'(i - 1)), i == 6, i == 7);
      $display("test channel change done");
      end_of_test();
   end
endmodule
